// file: core/bal_defs.svh
`ifndef BAL_DEFS_SVH
`define BAL_DEFS_SVH

// Flag word bit positions
`define BAL_FL_CF 0
`define BAL_FL_PF 2
`define BAL_FL_AF 4
`define BAL_FL_ZF 6
`define BAL_FL_SF 7
`define BAL_FL_OF 11

// Opcode bytes
`define BAL_OP_DIVPREP   8'hD5
`define BAL_OP_MULADJ    8'hD4
`define BAL_OP_BCD_BASE  8'h0A
`define BAL_OP_SUBADJ    8'h3F
`define BAL_OP_ADD_HI    5'h00
`define BAL_OP_ADC_HI    5'h02
`define BAL_OP_AND_HI    5'h04
`define BAL_OP_GRP_B     8'h80
`define BAL_OP_GRP_W     8'h81
`define BAL_OP_GRP_SX    8'h83
`define BAL_OP_RAISE     8'h63
`define BAL_REG_ADD      3'h0
`define BAL_REG_ADC      3'h2
`define BAL_REG_AND      3'h4

// Cycle counts
`define BAL_CYC_DIVPREP  5'h0E
`define BAL_CYC_MULADJ   5'h10
`define BAL_CYC_SUBADJ   5'h03
`define BAL_CYC_REG      5'h02
`define BAL_CYC_IMM      5'h03
`define BAL_CYC_MEM      5'h07
`define BAL_CYC_RAISE    5'h0A
`define BAL_CYC_RAISE_M  5'h0B
`define BAL_CYC_BAD      5'h02

// Fault vectors and error code
`define BAL_VEC_BADOP    8'h06
`define BAL_VEC_STACK    8'h0C
`define BAL_VEC_GP       8'h0D
`define BAL_ERR_CODE     16'h0000
`define BAL_WRAP_OFS     16'hFFFF
`define BAL_SEG_STACK    2'h3

// Register port map and reset values
`define BAL_ADDR_CTRL    4'h0
`define BAL_ADDR_STAT    4'h1
`define BAL_CTRL_RST     16'h0000
`define BAL_TEN          8'h0A
`define BAL_NINE         4'h9
`define BAL_SIX          8'h06

`endif

// file: core/bal_pkg.sv
package bal_pkg;

    typedef enum logic [1:0] {
        BAL_ST_IDLE = 2'b01,
        BAL_ST_BUSY = 2'b10
    } bal_state_t;

    typedef enum logic [7:0] {
        BAL_CL_NONE  = 8'b0000_0001,
        BAL_CL_DIVP  = 8'b0000_0010,
        BAL_CL_MULA  = 8'b0000_0100,
        BAL_CL_SUBA  = 8'b0000_1000,
        BAL_CL_ADD   = 8'b0001_0000,
        BAL_CL_ADC   = 8'b0010_0000,
        BAL_CL_AND   = 8'b0100_0000,
        BAL_CL_RAISE = 8'b1000_0000
    } bal_class_t;

    // One instruction handed over by the sequencer
    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  second;
        logic [15:0] op_a;
        logic [15:0] op_b;
        logic [15:0] flags;
        logic        mem;
        logic [15:0] offset;
        logic [1:0]  seg;
        logic        illegal;
        logic        writable;
    } bal_req_t;

    // Completed instruction
    typedef struct packed {
        logic [15:0] result;
        logic [15:0] flags;
        logic        wb;
        logic        fault;
        logic [7:0]  vector;
        logic [15:0] err_code;
    } bal_rsp_t;

endpackage

// file: core/bal_unit.sv
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "bal_defs.svh"

// Overview of operation
// - Opcode D5 0A is divide-prepare, taking 14 cycles.
// - Divide-prepare: low byte becomes low plus ten times high; high byte cleared.
// - Divide-prepare and multiply-adjust set sign, zero, parity; other flags kept.
// - Opcode D4 0A is multiply-adjust, taking 16 cycles.
// - Multiply-adjust: quotient of low byte by ten to high, remainder to low.
// - Opcode 3F is subtract-adjust, taking 3 cycles.
// - Low nibble above 9 or aux carry: subtract 6, decrement high, set CF AF.
// - Subtract-adjust always clears the upper nibble of the low byte.
// - Subtract-adjust defines only carry and auxiliary carry.
// - Sum at 00-05, sum with carry at 10-15, groups 80/81/83 reg 0 or 2.
// - Sum with carry adds the incoming carry; plain sum ignores it.
// - Sums are written back to the first operand.
// - Byte immediate on a word operand is sign-extended first.
// - Sums update all six arithmetic flags.
// - Register forms 2 or 7, accumulator immediate 3, group 3 or 7 cycles.
// - Protected mode: sum or conjunction to a non-writable destination segment gives protection fault code 0.
// - Protected mode: illegal address in a sum or conjunction faults, stack segment gives stack fault.
// - Real mode: word operand at offset FFFF raises interrupt 13.
// - Conjunction is bitwise and, opcodes 20-25 and groups 80/81 reg 4.
// - Conjunction clears overflow and carry and sets sign, zero, parity.
// - Privilege raise copies larger low two bits and sets zero, else clears zero.
// - Privilege raise takes 10 cycles, or 11 with a memory destination.
// - Real mode: privilege raise opcode raises interrupt 6.
module bal_unit
    import bal_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire bal_req_t    req_i,
    output logic             busy_o,
    output logic             done_o,
    output bal_rsp_t         rsp_o,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [15:0]      rdata_o
);

    bal_state_t  state_r;
    bal_class_t  cls_r;
    logic [4:0]  cnt_r;
    logic [4:0]  elap_r;
    logic        prot_r;
    logic [7:0]  last_vec_r;
    logic        last_fault_r;
    bal_rsp_t    rsp_r;
    logic [15:0] rdata_r;

    // Opcode decode
    wire  [7:0]  opc       = req_i.opcode;
    wire  [2:0]  reg_fld   = req_i.second[5:3];
    wire         alu_row   = (opc[2:0] <= 3'h5) && (opc[7:6] == 2'b00);
    wire         is_grp    = (opc == `BAL_OP_GRP_B) || (opc == `BAL_OP_GRP_W)
                             || (opc == `BAL_OP_GRP_SX);
    wire         grp_and   = (opc == `BAL_OP_GRP_B) || (opc == `BAL_OP_GRP_W);
    wire         is_word   = is_grp ? (opc != `BAL_OP_GRP_B) : opc[0];
    wire         acc_imm   = alu_row && opc[2];
    wire         dst_mem   = req_i.mem && (is_grp || !opc[1]);

    bal_class_t  cls;
    always_comb
    begin
        cls = BAL_CL_NONE;
        if (opc == `BAL_OP_DIVPREP && req_i.second == `BAL_OP_BCD_BASE)
            cls = BAL_CL_DIVP;
        else if (opc == `BAL_OP_MULADJ && req_i.second == `BAL_OP_BCD_BASE)
            cls = BAL_CL_MULA;
        else if (opc == `BAL_OP_SUBADJ)
            cls = BAL_CL_SUBA;
        else if (alu_row && opc[7:3] == `BAL_OP_ADD_HI)
            cls = BAL_CL_ADD;
        else if (alu_row && opc[7:3] == `BAL_OP_ADC_HI)
            cls = BAL_CL_ADC;
        else if (alu_row && opc[7:3] == `BAL_OP_AND_HI)
            cls = BAL_CL_AND;
        else if (is_grp && reg_fld == `BAL_REG_ADD)
            cls = BAL_CL_ADD;
        else if (is_grp && reg_fld == `BAL_REG_ADC)
            cls = BAL_CL_ADC;
        else if (grp_and && reg_fld == `BAL_REG_AND)
            cls = BAL_CL_AND;
        else if (opc == `BAL_OP_RAISE && prot_r)
            cls = BAL_CL_RAISE;
    end

    wire         arith     = (cls == BAL_CL_ADD) || (cls == BAL_CL_ADC) || (cls == BAL_CL_AND);

    // Cycle count per class and form
    wire  [4:0]  cyc_alu   = req_i.mem ? `BAL_CYC_MEM
                             : ((acc_imm || is_grp) ? `BAL_CYC_IMM : `BAL_CYC_REG);
    wire  [4:0]  cyc       = (cls == BAL_CL_DIVP)  ? `BAL_CYC_DIVPREP
                           : (cls == BAL_CL_MULA)  ? `BAL_CYC_MULADJ
                           : (cls == BAL_CL_SUBA)  ? `BAL_CYC_SUBADJ
                           : (cls == BAL_CL_RAISE) ? (req_i.mem ? `BAL_CYC_RAISE_M
                                                                : `BAL_CYC_RAISE)
                           : arith                 ? cyc_alu
                           :                         `BAL_CYC_BAD;

    // Second operand with byte immediate sign extension
    wire  [15:0] src_b     = (opc == `BAL_OP_GRP_SX) ? {{8{req_i.op_b[7]}}, req_i.op_b[7:0]}
                                                     : req_i.op_b;
    wire  [15:0] dst_a     = req_i.op_a;
    wire         cin       = (cls == BAL_CL_ADC) ? req_i.flags[`BAL_FL_CF] : 1'b0;
    wire  [16:0] sum       = {1'b0, dst_a} + {1'b0, src_b} + {16'h0000, cin};
    wire  [15:0] conj      = dst_a & src_b;
    wire  [15:0] alu_res   = (cls == BAL_CL_AND) ? conj : sum[15:0];
    wire         msb_res   = is_word ? alu_res[15] : alu_res[7];
    wire         msb_a     = is_word ? dst_a[15] : dst_a[7];
    wire         msb_b     = is_word ? src_b[15] : src_b[7];
    wire         zf_res    = is_word ? (alu_res == 16'h0000) : (alu_res[7:0] == 8'h00);
    wire         cf_sum    = is_word ? sum[16] : (dst_a[7:0] + src_b[7:0] + {7'h00, cin} > 9'h0FF);
    wire         of_sum    = (msb_a == msb_b) && (msb_res != msb_a);
    wire         af_sum    = dst_a[4] ^ src_b[4] ^ alu_res[4];

    // Decimal adjust datapaths
    wire  [7:0]  al        = dst_a[7:0];
    wire  [7:0]  ah        = dst_a[15:8];
    wire  [15:0] ah_x10    = {8'h00, ah} * {8'h00, `BAL_TEN};
    wire  [7:0]  divp_lo   = al + ah_x10[7:0];
    wire  [7:0]  mula_hi   = al / `BAL_TEN;
    wire  [7:0]  mula_lo   = al % `BAL_TEN;
    wire         suba_adj  = (al[3:0] > `BAL_NINE) || req_i.flags[`BAL_FL_AF];
    wire  [7:0]  suba_lo   = suba_adj ? (al - `BAL_SIX) : al;
    wire  [7:0]  suba_hi   = suba_adj ? (ah - 8'h01) : ah;

    // Privilege field raise
    wire         rpl_low   = dst_a[1:0] < src_b[1:0];
    wire  [15:0] raise_res = rpl_low ? {dst_a[15:2], src_b[1:0]} : dst_a;

    // Result and flags per class
    logic [15:0] res;
    logic [15:0] flg;
    always_comb
    begin
        res = dst_a;
        flg = req_i.flags;
        case (cls)
            BAL_CL_DIVP:
            begin
                res = {8'h00, divp_lo};
            end
            BAL_CL_MULA:
            begin
                res = {mula_hi, mula_lo};
            end
            BAL_CL_SUBA:
            begin
                res                = {suba_hi, 4'h0, suba_lo[3:0]};
                flg[`BAL_FL_CF]    = suba_adj;
                flg[`BAL_FL_AF]    = suba_adj;
            end
            BAL_CL_ADD, BAL_CL_ADC, BAL_CL_AND:
            begin
                res = is_word ? alu_res : {dst_a[15:8], alu_res[7:0]};
                flg[`BAL_FL_SF] = msb_res;
                flg[`BAL_FL_ZF] = zf_res;
                flg[`BAL_FL_PF] = ~^alu_res[7:0];
                if (cls == BAL_CL_AND)
                begin
                    flg[`BAL_FL_OF] = 1'b0;
                    flg[`BAL_FL_CF] = 1'b0;
                end
                else
                begin
                    flg[`BAL_FL_OF] = of_sum;
                    flg[`BAL_FL_CF] = cf_sum;
                    flg[`BAL_FL_AF] = af_sum;
                end
            end
            BAL_CL_RAISE:
            begin
                res             = raise_res;
                flg[`BAL_FL_ZF] = rpl_low;
            end
            default:
            begin
                res = dst_a;
            end
        endcase
        if (cls == BAL_CL_DIVP || cls == BAL_CL_MULA)
        begin
            flg[`BAL_FL_SF] = res[7];
            flg[`BAL_FL_ZF] = (res[7:0] == 8'h00);
            flg[`BAL_FL_PF] = ~^res[7:0];
        end
    end

    // Fault selection
    wire         f_stack   = prot_r && arith && req_i.mem && req_i.illegal
                             && (req_i.seg == `BAL_SEG_STACK);
    wire         f_gp_adr  = prot_r && arith && req_i.mem && req_i.illegal
                             && (req_i.seg != `BAL_SEG_STACK);
    wire         f_gp_wr   = prot_r && arith && dst_mem && !req_i.writable;
    wire         f_wrap    = !prot_r && arith && is_word && req_i.mem
                             && (req_i.offset == `BAL_WRAP_OFS);
    wire         f_bad     = (cls == BAL_CL_NONE);
    wire         fault     = f_stack || f_gp_adr || f_gp_wr || f_wrap || f_bad;
    wire  [7:0]  vec       = f_bad   ? `BAL_VEC_BADOP
                           : f_stack ? `BAL_VEC_STACK
                           :           `BAL_VEC_GP;
    wire         accept    = start_i && (state_r == BAL_ST_IDLE);
    wire         finish    = (state_r == BAL_ST_BUSY) && (cnt_r == 5'h01);

    // Sequencer: hold the instruction for its cycle count
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= BAL_ST_IDLE;
            cls_r   <= BAL_CL_NONE;
            cnt_r   <= 5'h00;
            elap_r  <= 5'h00;
            rsp_r   <= '0;
            done_o  <= 1'b0;
            busy_o  <= 1'b0;
        end
        else
        begin
            done_o <= finish;
            case (state_r)
                BAL_ST_IDLE:
                begin
                    if (accept)
                    begin
                        state_r        <= BAL_ST_BUSY;
                        busy_o         <= 1'b1;
                        cls_r          <= cls;
                        cnt_r          <= cyc;
                        elap_r         <= 5'h01;
                        rsp_r.result   <= res;
                        rsp_r.flags    <= fault ? req_i.flags : flg;
                        rsp_r.wb       <= !fault;
                        rsp_r.fault    <= fault;
                        rsp_r.vector   <= fault ? vec : 8'h00;
                        rsp_r.err_code <= `BAL_ERR_CODE;
                    end
                end
                BAL_ST_BUSY:
                begin
                    if (finish)
                    begin
                        state_r <= BAL_ST_IDLE;
                        busy_o  <= 1'b0;
                    end
                    else
                    begin
                        cnt_r  <= cnt_r - 5'h01;
                        elap_r <= elap_r + 5'h01;
                    end
                end
                default:
                begin
                    state_r <= BAL_ST_IDLE;
                end
            endcase
        end
    end

    assign rsp_o = rsp_r;

    // Register port: mode control and last outcome status
    wire         sel_ctrl  = (addr_i == `BAL_ADDR_CTRL);
    wire         sel_stat  = (addr_i == `BAL_ADDR_STAT);
    wire  [15:0] rd_mux    = sel_ctrl ? {15'h0000, prot_r}
                           : sel_stat ? {last_vec_r, 6'h00, last_fault_r, busy_o}
                           :            16'h0000;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prot_r       <= 1'(`BAL_CTRL_RST);                    // Real mode out of reset
            last_vec_r   <= 8'h00;
            last_fault_r <= 1'b0;
            rdata_r      <= 16'h0000;
        end
        else
        begin
            if (wr_i && sel_ctrl)
                prot_r <= wdata_i[0];
            if (finish)
            begin
                last_vec_r   <= rsp_r.vector;
                last_fault_r <= rsp_r.fault;
            end
            rdata_r <= rd_i ? rd_mux : 16'h0000;
        end
    end

    assign rdata_o = rdata_r;

    // Checks on timing and results
    chk_divp_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && cls_r == BAL_CL_DIVP |-> elap_r == 5'd14)
        else $error("divide-prepare cycle count wrong");
    chk_mula_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && cls_r == BAL_CL_MULA |-> elap_r == 5'd16)
        else $error("multiply-adjust cycle count wrong");
    chk_suba_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        accept && cls == BAL_CL_SUBA |=> !done_o [*3] ##1 done_o)
        else $error("subtract-adjust cycle count wrong");
    chk_raise_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        accept && cls == BAL_CL_RAISE && req_i.mem |=> !done_o [*8] ##1 !done_o [*3] ##1 done_o)
        else $error("privilege raise cycle count wrong");
    chk_reg_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        accept && arith && !req_i.mem && !acc_imm && !is_grp |=> !done_o [*2] ##1 done_o)
        else $error("register form cycle count wrong");
    chk_mem_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        accept && arith && req_i.mem |=> !done_o [*7] ##1 done_o)
        else $error("memory form cycle count wrong");
    chk_divp_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && cls_r == BAL_CL_DIVP |-> rsp_o.result[15:8] == 8'h00)
        else $error("divide-prepare high byte not cleared");
    chk_suba_nibble: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && cls_r == BAL_CL_SUBA |-> rsp_o.result[7:4] == 4'h0)
        else $error("subtract-adjust upper nibble not zero");
    chk_conj_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && cls_r == BAL_CL_AND && !rsp_o.fault
        |-> !rsp_o.flags[`BAL_FL_OF] && !rsp_o.flags[`BAL_FL_CF])
        else $error("conjunction overflow or carry set");
    chk_parity_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_o && !rsp_o.fault && (cls_r == BAL_CL_ADD || cls_r == BAL_CL_AND)
        |-> rsp_o.flags[`BAL_FL_PF] == ~^rsp_o.result[7:0])
        else $error("parity flag mismatch");
    chk_real_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        accept && f_wrap |=> rsp_o.fault && rsp_o.vector == `BAL_VEC_GP)
        else $error("real mode wrap did not fault");
    chk_stack_fault: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        accept && f_stack |=> rsp_o.fault && rsp_o.vector == `BAL_VEC_STACK && !rsp_o.wb)
        else $error("stack segment fault not reported");
    chk_raise_real: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        accept && !prot_r && opc == `BAL_OP_RAISE |=> rsp_o.fault && rsp_o.vector == `BAL_VEC_BADOP)
        else $error("privilege raise accepted in real mode");

endmodule

`default_nettype wire

// file: test/bal_seq_model.sv
`timescale 1ns/1ps
`default_nettype none

// Sequencer model: holds each request until the unit takes it
module bal_seq_model
    import bal_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic busy_i,
    output bal_req_t  req_o,
    output logic      start_o
);
    // Quiet lines at time zero
    initial
    begin
        start_o = 1'b0;
        req_o   = '0;
    end

    // Request stands until an edge finds the unit idle, so back to back works
    task automatic issue(input bal_req_t r);
        start_o <= 1'b1;
        req_o   <= r;
        do @(posedge clk_i); while (busy_i);
    endtask

    // Released request lines carry the inverse of the old request, never the old value
    task automatic quiet();
        start_o <= 1'b0;
        req_o   <= ~req_o;
        @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

// file: test/bal_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "bal_defs.svh"

module bal_unit_bench
    import bal_pkg::*;
;
    typedef struct {
        bal_rsp_t rsp;
        int       cyc;
        int       kind;
    } bal_note_t;

    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        start_i;
    bal_req_t    req_i;
    logic        busy_o;
    logic        done_o;
    bal_rsp_t    rsp_o;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic [15:0] rdata_o;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        rd_d = 1'b0;
    logic [15:0] rnd = 16'h0058;
    logic [15:0] a;
    logic [15:0] b;
    logic [7:0]  sb;
    int          n_errors = 0;
    int          total_checks = 0;
    int          lat = 0;
    int          k;
    bal_note_t   exp_q[$];
    logic [15:0] rd_q[$];
    logic [7:0]  op_t[12] = '{8'h01, 8'h11, 8'h21, 8'h83, 8'h83, 8'h81,
                              8'h05, 8'h15, 8'h25, 8'hD5, 8'hD4, 8'h3F};
    int          cy_t[12] = '{2, 2, 2, 3, 3, 3, 3, 3, 3, 14, 16, 3};

    always #2.5 clk_i = ~clk_i;

    bal_unit dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .req_i(req_i),
        .busy_o(busy_o), .done_o(done_o), .rsp_o(rsp_o), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));

    bal_seq_model seq_u (.clk_i(clk_i), .busy_i(busy_o), .req_o(req_i), .start_o(start_i));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic bal_req_t mk(input logic [7:0] o, s, input logic [15:0] x, y, f,
                                    input logic m, input logic [15:0] ofs,
                                    input logic [1:0] g, input logic il, w);
        return {o, s, x, y, f, m, ofs, g, il, w};
    endfunction

    // Reference result: 0 sum, 1 sum with carry, 2 and, 3 div prep, 4 mul adj,
    // 5 sub adj, 6 privilege raise
    function automatic bal_rsp_t model(input bal_req_t q, input int kd);
        logic [15:0] x, y, r, f;
        logic [16:0] s;
        logic [4:0]  h;
        logic        c;
        x = q.op_a;
        y = (q.opcode == 8'h83) ? {{8{q.op_b[7]}}, q.op_b[7:0]} : q.op_b;
        c = (kd == 1) & q.flags[`BAL_FL_CF];
        s = x + y + c;
        h = x[3:0] + y[3:0] + c;
        f = q.flags;
        r = s[15:0];
        if (kd == 2) r = x & y;
        if (kd == 3) r = {8'h00, x[7:0] + 8'(x[15:8] * 8'h0A)};
        if (kd == 4) r = {x[7:0] / 8'h0A, x[7:0] % 8'h0A};
        if (kd == 6) r = (x[1:0] < y[1:0]) ? {x[15:2], y[1:0]} : x;
        if (kd < 2)
        begin
            f[`BAL_FL_CF] = s[16];
            f[`BAL_FL_AF] = h[4];
            f[`BAL_FL_OF] = (x[15] == y[15]) && (r[15] != x[15]);
        end
        if (kd == 2)
        begin
            f[`BAL_FL_CF] = 1'b0;
            f[`BAL_FL_OF] = 1'b0;
        end
        if (kd < 5)
        begin
            f[`BAL_FL_ZF] = (kd > 2) ? (r[7:0] == 8'h00) : (r == 16'h0000);
            f[`BAL_FL_SF] = (kd > 2) ? r[7] : r[15];
            f[`BAL_FL_PF] = ~^r[7:0];
        end
        if (kd == 5)
        begin
            c = (x[3:0] > 4'h9) || q.flags[`BAL_FL_AF];
            r = c ? {x[15:8] - 8'h01, (x[7:0] - 8'h06) & 8'h0F} : {x[15:8], x[7:0] & 8'h0F};
            f[`BAL_FL_CF] = c;
            f[`BAL_FL_AF] = c;
        end
        if (kd == 6) f[`BAL_FL_ZF] = x[1:0] < y[1:0];
        return {r, f, 1'b1, 1'b0, 8'h00, 16'h0000};
    endfunction

    task automatic stop_test();
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic fail(input string m);
        n_errors++;
        $display("ERROR %0t %s", $time, m);
    endtask

    // Compares one completed instruction with its note
    task automatic chk_rsp(input bal_rsp_t g, input bal_note_t n);
        bal_rsp_t e;
        e = n.rsp;
        total_checks += 6;
        if (n.cyc != 0 && lat != n.cyc) fail("latency");
        if (busy_o !== 1'b0) fail("busy in done cycle");
        if ({g.fault, g.vector, g.err_code} !== {e.fault, e.vector, e.err_code}) fail("fault");
        if (g.flags !== e.flags) fail("flags");
        if (!e.fault && g.result !== e.result) fail("result");
        if (n.kind != 6 && g.wb !== !e.fault) fail("write back");
    endtask

    task automatic chk_rd(input logic [15:0] g, input logic [15:0] w);
        total_checks++;
        if (g !== w) fail("read data");
    endtask

    task automatic wr(input logic [3:0] ad, input logic [15:0] d);
        addr_i  <= ad;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [3:0] ad, input logic [15:0] w);
        rd_q.push_back(w);
        addr_i <= ad;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        @(posedge clk_i);
    endtask

    // Notes the expected answer, then hands the request to the sequencer
    task automatic send(input bal_req_t q, input int kd, input int c, input logic [7:0] v);
        bal_note_t n;
        n.rsp = model(q, kd);
        if (v != 8'h00)
            n.rsp = {16'h0000, q.flags, 1'b0, 1'b1, v, 16'h0000};
        n.cyc = c;
        n.kind = kd;
        exp_q.push_back(n);
        seq_u.issue(q);
    endtask

    task automatic drain();
        seq_u.quiet();
        for (int t = 0; t < 60 && exp_q.size() > 0; t++)
            @(posedge clk_i);
        if (exp_q.size() > 0) fail("missing result");
    endtask

    // Takes the oldest note whenever a result or read data appears
    always @(posedge clk_i)
    begin
        if (done_o === 1'b1)
            if (exp_q.size() == 0) fail("unexpected done");
            else chk_rsp(rsp_o, exp_q.pop_front());
        if (rd_d && rd_q.size() > 0) chk_rd(rdata_o, rd_q.pop_front());
        lat = (start_i && !busy_o) ? 0 : lat + 1;
        rd_d <= rd_i;
    end

    initial
    begin
        #20000;
        fail("timeout");
        stop_test();
    end

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(`BAL_ADDR_CTRL, `BAL_CTRL_RST);
        rd(4'h5, 16'h0000);
        // Every class but raise in word register, immediate and group forms, random operands and flags, issued back to back
        for (int i = 0; i < 24; i++)
        begin
            k = i % 12;
            rnd = lfsr(rnd);
            a = rnd;
            rnd = lfsr(rnd);
            b = rnd;
            rnd = lfsr(rnd);
            sb = (k > 8) ? `BAL_OP_BCD_BASE : {2'b11, (k == 4) ? 3'h2 : (k == 5) ? 3'h4 : 3'h0, 3'h0};
            send(mk(op_t[k], sb, a, b, rnd, 1'b0, 16'h0000, 2'h1, 1'b0, 1'b1),
                 (k < 9) ? k % 3 : k - 6, cy_t[k], 8'h00);
        end
        send(mk(8'h3F, 8'h00, 16'h050B, b, 16'h0000, 1'b0, 16'h0, 2'h1, 1'b0, 1'b1), 5, 3, 8'h00);
        send(mk(8'h3F, 8'h00, 16'h0012, b, 16'h0010, 1'b0, 16'h0, 2'h1, 1'b0, 1'b1), 5, 3, 8'h00);
        send(mk(8'h3F, 8'h00, 16'h0729, b, 16'h0000, 1'b0, 16'h0, 2'h1, 1'b0, 1'b1), 5, 3, 8'h00);
        send(mk(8'hD5, 8'h0A, 16'h0909, b, 16'h0000, 1'b0, 16'h0, 2'h1, 1'b0, 1'b1), 3, 14, 8'h00);
        send(mk(8'hD4, 8'h0A, 16'h0063, b, 16'h0000, 1'b0, 16'h0, 2'h1, 1'b0, 1'b1), 4, 16, 8'h00);
        send(mk(8'h01, 8'h00, a, b, rnd, 1'b1, 16'h1234, 2'h1, 1'b0, 1'b1), 0, 7, 8'h00);
        send(mk(8'h01, 8'h00, a, b, rnd, 1'b1, 16'hFFFF, 2'h1, 1'b0, 1'b1), 0, 7, 8'h0D);
        send(mk(8'h63, 8'hC0, a, b, rnd, 1'b0, 16'h0, 2'h1, 1'b0, 1'b1), 6, 2, 8'h06);
        send(mk(8'hD5, 8'h0B, a, b, rnd, 1'b0, 16'h0, 2'h1, 1'b0, 1'b1), 3, 2, 8'h06);
        drain();
        rd(`BAL_ADDR_STAT, 16'h0602);
        wr(`BAL_ADDR_CTRL, 16'h0001);
        rd(`BAL_ADDR_CTRL, 16'h0001);
        // Protected mode: both raise branches, register and memory destinations
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            send(mk(8'h63, 8'hC0, {rnd[15:2], 2'(i)}, {rnd[13:0], ~2'(i)}, rnd, i[0],
                 16'h0010, 2'h1, 1'b0, 1'b1), 6, i[0] ? 11 : 10, 8'h00);
        end
        send(mk(8'h81, 8'h20, a, b, rnd, 1'b1, 16'h0, 2'h1, 1'b0, 1'b0), 2, 7, 8'h0D);
        send(mk(8'h01, 8'h00, a, b, rnd, 1'b1, 16'h0, 2'h3, 1'b1, 1'b1), 0, 7, 8'h0C);
        send(mk(8'h11, 8'h00, a, b, rnd, 1'b1, 16'h0, 2'h0, 1'b1, 1'b1), 1, 7, 8'h0D);
        drain();
        stop_test();
    end
endmodule

`default_nettype wire
